/* hw/ddr_read_map.vh */
`ifndef DDR_READ_MAP_VH
`define DDR_READ_MAP_VH

// command code on {ras_n, cas_n, we_n} while cs_n is low
`define CMD_ACTIVATE 3'h3
`define CMD_READ 3'h5
`define CMD_PRECHARGE 3'h2
`define CMD_WRITE 3'h4

// field positions on the address pins
`define PRE_SEL_BIT 10
`define COL_LSB 0

// burst lengths in data elements
`define BURST_SHORT 4'h4
`define BURST_LONG 4'h8

// read_to_precharge_time floor, in link clocks
`define RTP_FLOOR 5'h02
// default read_to_precharge_time, in link clocks
`define RTP_TICKS_DEF 5'h02

// depth of the queue of reads still waiting out their latency
`define RD_QDEPTH 4

// reset values
`define TICK_RST 8'h00
`define PIN_RST 1'b0
`define STRB_RST 1'b0

`endif

/* hw/link_sampler.v */
// two-flop synchroniser for a pin group, with edge detection on bit 0
module link_sampler #(
  parameter W = 22
) (
  input wire clk,
  input wire reset_n,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync,
  output wire rise,
  output wire fall
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  reg last_q;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q[0];
    end
  end

  assign pin_sync = sync_q;
  assign rise = sync_q[0] & ~last_q;
  assign fall = ~sync_q[0] & last_q;
endmodule

/* hw/read_buffer.v */
// two-entry buffer; in_ready falls only when both entries hold words
module read_buffer #(
  parameter W = 9
) (
  input wire clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push & ~pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule

/* hw/ddr_read_path.v */
// How it works
// - read carries bank, column and auto precharge choice; precharge closes row after burst
// - first element appears read_latency = additive_latency + cas_latency clocks after read
// - each further element follows at the next rising or falling clock edge
// - strobe driven with data; preamble holds strobe low, complement high
// - strobe low, complement high with the last element as postamble
// - data and strobe pins released when burst ends with nothing following
// - eight-element burst truncated by any read that falls due while it runs, on any element
// - interrupting read may use any bank and either precharge choice
// - random reads across open pages and banks run at full speed while fewer than 4 earlier reads still wait out their latency
// - precharge_select_address_bit high on a read selects auto precharge
// - auto precharge at additive_latency + burst_length/2, pushed out until rtp is met
`include "ddr_read_map.vh"

module ddr_read_path #(
  parameter DQ_W = 8,
  parameter RTP_TICKS = `RTP_TICKS_DEF
) (
  input wire clk,
  input wire reset_n,
  input wire ck,
  input wire clock_complement,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [2:0] ba,
  input wire [13:0] addr,
  input wire [DQ_W-1:0] dq_i,
  output wire [DQ_W-1:0] dq_o,
  output wire dq_oe,
  input wire dqs_i,
  output wire dqs_o,
  output wire dqs_n_o,
  output wire dqs_oe,
  input wire [2:0] additive_latency,
  input wire [2:0] cas_latency,
  input wire burst_length_8,
  input wire drive_stall,
  input wire load_we,
  input wire [5:0] load_addr,
  input wire [DQ_W-1:0] load_data,
  output wire [7:0] bank_open,
  output wire read_err,
  output wire burst_active
);
  localparam PW = 23;
  localparam QD = `RD_QDEPTH;

  // storage behind the pins: 8 banks of 8 columns
  reg [DQ_W-1:0] mem [0:63];

  wire [PW-1:0] pins_s;
  wire ck_rise;
  wire ck_fall;
  wire [2:0] cmd_s;
  wire [2:0] ba_s;
  wire [13:0] addr_s;
  wire cmd_ok;
  wire is_read;
  wire is_act;
  wire is_pre;

  // clock_complement rides along only for symmetry; ck alone marks edges
  link_sampler #(.W(PW)) u_sampler (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({clock_complement, addr, ba, we_n, cas_n, ras_n, cs_n, ck}),
    .pin_sync(pins_s),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  assign cmd_s = {pins_s[2], pins_s[3], pins_s[4]};
  assign ba_s = pins_s[7:5];
  assign addr_s = pins_s[21:8];
  assign cmd_ok = ck_rise & ~pins_s[1];
  assign is_read = cmd_ok & (cmd_s == `CMD_READ);
  assign is_act = cmd_ok & (cmd_s == `CMD_ACTIVATE);
  assign is_pre = cmd_ok & (cmd_s == `CMD_PRECHARGE);

  // sequential wrap inside the burst
  function [2:0] burst_col;
    input [2:0] col;
    input [2:0] beat;
    input long;
    begin
      if (long)
        burst_col = col + beat;
      else
        burst_col = {col[2], col[1:0] + beat[1:0]};
    end
  endfunction

  reg [7:0] tick_q;
  reg [7:0] q_start [0:QD-1];
  reg [2:0] q_bank [0:QD-1];
  reg [2:0] q_col [0:QD-1];
  reg [1:0] q_rd_q;
  reg [1:0] q_wr_q;
  reg [2:0] q_cnt_q;
  reg [3:0] left_q;
  reg [2:0] beat_q;
  reg [2:0] bank_q;
  reg [2:0] col_q;
  reg st_valid_q;
  reg [DQ_W:0] st_data_q;
  reg [DQ_W-1:0] dq_q;
  reg dqs_q;
  reg oe_q;
  reg err_q;
  reg [7:0] open_q;
  reg edge_d1_q;
  reg edge_d2_q;

  wire [7:0] read_start;
  wire q_full;
  wire q_due;
  wire q_next_due;
  wire [3:0] burst_len;
  wire [3:0] eff_left;
  wire [2:0] eff_beat;
  wire [2:0] eff_bank;
  wire [2:0] eff_col;
  wire edge_ev;
  wire st_free;
  wire emit;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [DQ_W:0] buf_out_data;
  wire [2:0] emit_col;
  wire pin_ready;

  assign read_start = tick_q + {5'h00, additive_latency} + {5'h00, cas_latency};
  assign q_full = (q_cnt_q == QD[2:0]);
  assign q_due = (q_cnt_q != 3'h0) & (q_start[q_rd_q] == tick_q);
  assign q_next_due = (q_cnt_q != 3'h0) & (q_start[q_rd_q] == tick_q + 8'h01);
  assign burst_len = burst_length_8 ? `BURST_LONG : `BURST_SHORT;

  // a read falling due replaces whatever burst is running, which is how a
  // long burst gets cut at whatever element it has reached
  assign eff_left = (ck_rise & q_due) ? burst_len : left_q;
  assign eff_beat = (ck_rise & q_due) ? 3'h0 : beat_q;
  assign eff_bank = (ck_rise & q_due) ? q_bank[q_rd_q] : bank_q;
  assign eff_col = (ck_rise & q_due) ? q_col[q_rd_q] : col_q;

  assign edge_ev = ck_rise | ck_fall;
  assign st_free = ~st_valid_q | buf_in_ready;
  // a stalled buffer holds the burst back rather than dropping a word
  assign emit = edge_ev & (eff_left != 4'h0) & st_free;
  assign emit_col = burst_col(eff_col, eff_beat, burst_length_8);
  // the pin side takes one word per link edge, two clocks after it, so a
  // drained backlog keeps the half-period spacing instead of bunching up
  assign pin_ready = ~drive_stall & edge_d2_q;

  always @(posedge clk)
  begin
    if (load_we)
      mem[load_addr] <= load_data;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      tick_q <= `TICK_RST;
      q_rd_q <= 2'h0;
      q_wr_q <= 2'h0;
      q_cnt_q <= 3'h0;
      left_q <= 4'h0;
      beat_q <= 3'h0;
      bank_q <= 3'h0;
      col_q <= 3'h0;
      st_valid_q <= 1'b0;
      st_data_q <= {(DQ_W+1){1'b0}};
      err_q <= 1'b0;
      edge_d1_q <= 1'b0;
      edge_d2_q <= 1'b0;
    end
    else
    begin
      if (ck_rise)
        tick_q <= tick_q + 8'h01;
      if (is_read & ~q_full)
      begin
        q_start[q_wr_q] <= read_start;
        q_bank[q_wr_q] <= ba_s;
        q_col[q_wr_q] <= addr_s[`COL_LSB+2:`COL_LSB];
        q_wr_q <= q_wr_q + 2'h1;
      end
      if (ck_rise & q_due)
        q_rd_q <= q_rd_q + 2'h1;
      if ((is_read & ~q_full) & ~(ck_rise & q_due))
        q_cnt_q <= q_cnt_q + 3'h1;
      else if (~(is_read & ~q_full) & (ck_rise & q_due))
        q_cnt_q <= q_cnt_q - 3'h1;
      // a burst loaded now keeps its place even if this edge is stalled
      if (ck_rise & q_due)
      begin
        left_q <= burst_len;
        beat_q <= 3'h0;
        bank_q <= q_bank[q_rd_q];
        col_q <= q_col[q_rd_q];
      end
      if (emit)
      begin
        left_q <= eff_left - 4'h1;
        beat_q <= eff_beat + 3'h1;
        // strobe follows beat parity, not the link edge, so a stalled burst
        // still alternates and its odd last beat carries the low postamble
        st_data_q <= {~eff_beat[0], mem[{eff_bank, emit_col}]};
        st_valid_q <= 1'b1;
      end
      else if (buf_in_ready)
        st_valid_q <= 1'b0;
      err_q <= is_read & (q_full | ~open_q[ba_s]);
      edge_d1_q <= edge_ev;
      edge_d2_q <= edge_d1_q;
    end
  end

  read_buffer #(.W(DQ_W+1)) u_buffer (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(st_valid_q),
    .in_ready(buf_in_ready),
    .in_data(st_data_q),
    .out_valid(buf_out_valid),
    .out_ready(pin_ready),
    .out_data(buf_out_data)
  );

  // pin side: drivers turn on for the preamble clock and off only on a
  // rising edge that neither continues a burst nor starts a preamble
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      dq_q <= {DQ_W{`PIN_RST}};
      dqs_q <= `STRB_RST;
      oe_q <= 1'b0;
    end
    else
    begin
      if (buf_out_valid & pin_ready)
      begin
        dq_q <= buf_out_data[DQ_W-1:0];
        dqs_q <= buf_out_data[DQ_W];
      end
      if (ck_rise)
      begin
        // words still queued after a stall keep the drivers on
        if ((eff_left != 4'h0) | st_valid_q | buf_out_valid)
          oe_q <= 1'b1;
        else if (q_next_due)
        begin
          oe_q <= 1'b1;
          dqs_q <= 1'b0;
        end
        else
          oe_q <= 1'b0;
      end
    end
  end

  // bank rows: activate opens, precharge or a finished auto precharge closes
  wire [4:0] ap_delay;
  wire [4:0] rtp_eff;
  assign rtp_eff = (RTP_TICKS[4:0] > `RTP_FLOOR) ? RTP_TICKS[4:0] : `RTP_FLOOR;
  // additive_latency + burst_length/2 - 2 + max(rtp, 2)
  assign ap_delay = {2'h0, additive_latency} + {2'h0, burst_len[3:1]} - 5'h02
    + rtp_eff;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_bank
      reg [4:0] ap_cnt_q;
      always @(posedge clk)
      begin
        if (!reset_n)
        begin
          open_q[gi] <= 1'b0;
          ap_cnt_q <= 5'h00;
        end
        else if (ck_rise)
        begin
          if (is_act & (ba_s == gi))
            open_q[gi] <= 1'b1;
          else if (is_pre & ((ba_s == gi) | addr_s[`PRE_SEL_BIT]))
          begin
            open_q[gi] <= 1'b0;
            ap_cnt_q <= 5'h00;
          end
          else if (is_read & (ba_s == gi) & addr_s[`PRE_SEL_BIT])
            ap_cnt_q <= ap_delay;
          else if (ap_cnt_q != 5'h00)
          begin
            ap_cnt_q <= ap_cnt_q - 5'h01;
            if (ap_cnt_q == 5'h01)
              open_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign dq_o = dq_q;
  assign dq_oe = oe_q;
  assign dqs_o = dqs_q;
  assign dqs_n_o = ~dqs_q;
  assign dqs_oe = oe_q;
  assign bank_open = open_q;
  assign read_err = err_q;
  assign burst_active = (left_q != 4'h0);
endmodule

/* dv/ddr_read_path_assertions.sv */
module read_path_checker #(
  parameter DQ_W = 8
) (
  input logic clk,
  input logic reset_n,
  input logic [DQ_W-1:0] dq_o,
  input logic dq_oe,
  input logic dqs_o,
  input logic dqs_n_o,
  input logic dqs_oe,
  input logic [7:0] bank_open,
  input logic read_err,
  input logic burst_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_strobe_compl: assert property (dqs_n_o == !dqs_o)
    else $error("strobe pair not complementary");
  a_enable_pair: assert property (dq_oe == dqs_oe)
    else $error("data and strobe enables differ");
  a_reset_idle: assert property (disable iff (1'b0)
    !reset_n |=> !dq_oe && !read_err && !burst_active && bank_open == 8'h00)
    else $error("outputs not idle after reset");
  a_preamble_low: assert property ($rose(dq_oe) |-> !dqs_o)
    else $error("strobe not low in preamble");
  a_postamble_low: assert property ($fell(dq_oe) |-> !$past(dqs_o))
    else $error("strobe not low with last element");
  a_busy_drives: assert property (burst_active |-> dq_oe)
    else $error("burst pending while pins released");
  a_data_strobed: assert property (
    $past(dq_oe) && dq_oe && $changed(dq_o) |-> $changed(dqs_o))
    else $error("data changed without strobe edge");
  a_edge_spacing: assert property (dq_oe && $changed(dqs_o) |=> $stable(dqs_o) [*3])
    else $error("elements closer than one clock edge");
  a_err_pulse: assert property (read_err |=> !read_err)
    else $error("error flag longer than one cycle");
endmodule

bind ddr_read_path read_path_checker #(.DQ_W(DQ_W)) i_chk (.clk(clk), .reset_n(reset_n),
  .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o), .dqs_oe(dqs_oe),
  .bank_open(bank_open), .read_err(read_err), .burst_active(burst_active));

/* dv/ctrl_model.sv */
module ctrl_model (
  input logic clk,
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 0;
  logic [3:0] nc = 4'hF;
  logic [2:0] nb = 3'h0;
  logic [13:0] na = 14'h0000;
  initial ck = 1'b0;
  initial rises = 0;
  // memory clock runs free, 4 system clocks per half period
  always @(negedge clk)
  begin
    div <= (div == 3) ? 0 : div + 1;
    if (div == 3) ck <= ~ck;
  end
  always @(posedge ck) rises <= rises + 1;
  // pins change on the link fall and hold a whole period; deselect when idle
  always @(negedge ck)
  begin
    {cs_n, ras_n, cas_n, we_n} <= nc;
    ba <= nb;
    addr <= na;
    nc <= 4'hF;
  end
  initial {cs_n, ras_n, cas_n, we_n, ba, addr} = {4'hF, 3'h0, 14'h0000};
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    {nc, nb, na} = {c, b, a};
    @(negedge ck);
    @(posedge ck);
    #1;
  endtask
endmodule

/* dv/tb_top.sv */
`include "ddr_read_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, ck, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_o, dqs_oe, read_err, busy;
  logic [2:0] ba, al = 3'h0, cl = 3'h3;
  logic [13:0] addr;
  logic bl8 = 0, stall = 0, lwe = 0, pdqs = 0;
  logic [5:0] la = 6'h00;
  logic [7:0] ld = 8'h00, dq_o, bank_open;
  int rises, errors = 0, checked = 0, errs_seen = 0, t;
  logic [7:0] got[$], exp[$];
  always #12.5 clk = ~clk;
  ctrl_model i_ctl (.clk(clk), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .rises(rises));
  // released lines show the inverse of the last value, never a held copy
  ddr_read_path i_dut (.clk(clk), .reset_n(reset_n), .ck(ck), .clock_complement(~ck),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .dq_i(dq_oe ? dq_o : ~dq_o), .dq_o(dq_o), .dq_oe(dq_oe),
    .dqs_i(dqs_oe ? dqs_o : ~dqs_o), .dqs_o(dqs_o), .dqs_n_o(), .dqs_oe(dqs_oe),
    .additive_latency(al), .cas_latency(cl), .burst_length_8(bl8), .drive_stall(stall),
    .load_we(lwe), .load_addr(la), .load_data(ld), .bank_open(bank_open),
    .read_err(read_err), .burst_active(busy));
  // outputs are looked at on the falling edge, where they have settled
  always @(negedge clk)
  begin
    if (dq_oe === 1'b1 && dqs_o !== pdqs) got.push_back(dq_o);
    pdqs <= dqs_o;
    if (read_err === 1'b1) errs_seen++;
  end
  function automatic logic [7:0] word(input logic [5:0] i);
    return {2'b00, i} ^ 8'hA5;
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) i_ctl.issue(4'hF, 3'h0, 14'h0000);
  endtask
  task automatic rd(input logic [2:0] b, input logic [2:0] c, input logic ap, input int n);
    logic [2:0] col;
    i_ctl.issue({1'b0, `CMD_READ}, b, {3'b000, ap, 7'h00, c});
    t = rises;
    for (int k = 0; k < n; k++)
    begin
      col = bl8 ? c + 3'(k) : {c[2], c[1:0] + 2'(k)};
      exp.push_back(word({b, col}));
    end
  endtask
  task automatic finish_test(input string name);
    int n;
    n = 0;
    idle(8);
    @(negedge clk);
    while (dq_oe !== 1'b0 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("release", 16'h0001, {15'h0000, n < 400});
    chk("count", 16'(exp.size()), 16'(got.size()));
    while (exp.size() > 0 && got.size() > 0)
      chk("data", exp.pop_front(), got.pop_front());
    exp.delete();
    got.delete();
    $display("test %s done", name);
  endtask
  task automatic lat(input logic [2:0] a, input logic [2:0] c);
    int n;
    n = 0;
    @(negedge clk);
    {al, cl} = {a, c};
    idle(1);
    rd(3'h0, 3'h1, 1'b0, 4);
    while (dq_oe !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("preamble rise", 16'(t + a + c - 1), 16'(rises));
    finish_test("latency");
  endtask
  task tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #500us;
    errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(negedge clk);
    reset_n = 1;
    for (int i = 0; i < 64; i++)
    begin
      @(negedge clk);
      {lwe, la, ld} = {1'b1, 6'(i), word(6'(i))};
    end
    @(negedge clk) lwe = 0;
    for (int b = 0; b < 8; b++) i_ctl.issue({1'b0, `CMD_ACTIVATE}, 3'(b), 14'h0000);
    idle(1);
    chk("rows open", 16'h00FF, {8'h00, bank_open});
    lat(3'h0, 3'h3);
    lat(3'h1, 3'h3);
    lat(3'h2, 3'h4);
    lat(3'h0, 3'h5);
    {al, cl} = {3'h0, 3'h3};
    rd(3'h2, 3'h3, 1'b0, 4);
    idle(1);
    rd(3'h5, 3'h6, 1'b0, 4);
    finish_test("seamless");
    bl8 = 1;
    rd(3'h4, 3'h2, 1'b0, 4);
    idle(1);
    rd(3'h3, 3'h5, 1'b1, 8);
    // auto close is due on the fourth link rise after the read
    idle(3);
    chk("open before auto close", 16'h0001, {15'h0000, bank_open[3]});
    idle(2);
    chk("auto close", 16'h0000, {15'h0000, bank_open[3]});
    finish_test("truncate");
    i_ctl.issue({1'b0, `CMD_PRECHARGE}, 3'h4, 14'h0000);
    idle(3);
    chk("precharged", 16'h0000, {15'h0000, bank_open[4]});
    chk("still open", 16'h0001, {15'h0000, bank_open[6]});
    rd(3'h4, 3'h0, 1'b0, 8);
    finish_test("closed bank");
    chk("error pulses", 16'h0001, 16'(errs_seen));
    rd(3'h6, 3'h1, 1'b0, 8);
    idle(3);
    @(negedge clk) stall = 1;
    repeat (20) @(negedge clk);
    stall = 0;
    finish_test("stall");
    // precharge with the select bit high closes every bank at once
    i_ctl.issue({1'b0, `CMD_PRECHARGE}, 3'h0, 14'h0400);
    idle(1);
    chk("all closed", 16'h0000, {8'h00, bank_open});
    $display("test precharge all done");
    tally_and_finish;
  end
endmodule
